// ### src/cbb_pkg.sv
// Shared constants, types and decoders for the CAN bus-bias controller
package cbb_pkg;

   // ----------
   // Timing
   // ----------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SILENCE_TIME_NS = 1_000_000;
   localparam int unsigned SILENCE_CYC =
      (SILENCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WAKE_FILTER_TIME_NS = 1_000;
   localparam int unsigned WAKE_FILTER_CYC =
      (WAKE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------
   // Register map
   // ----------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned STAT_BIAS_LSB = 0;
   localparam int unsigned STAT_WAKE_BIT = 2;
   localparam int unsigned STAT_BLOCK_BIT = 3;
   localparam int unsigned STAT_SILENT_BIT = 4;
   localparam int unsigned STAT_DRIVE_BIT = 5;

   // ----------
   // Types
   // ----------
   typedef enum logic [1:0] {
      BIAS_OFF = 2'b00,
      BIAS_AUTO_INACT = 2'b01,
      BIAS_AUTO_ACT = 2'b10,
      BIAS_ACTIVE = 2'b11
   } cbb_bias_t;

   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b000,
      MODE_SILENT = 3'b001,
      MODE_STANDBY = 3'b010,
      MODE_GO_SLEEP = 3'b011,
      MODE_SLEEP = 3'b100
   } cbb_mode_t;

   localparam logic [2:0] CTRL_MODE_RESET = MODE_STANDBY;

   // ----------
   // Mode decoders
   // ----------
   function automatic logic is_normal(input logic [2:0] m);
      return m == MODE_NORMAL;
   endfunction

   function automatic logic is_on_mode(input logic [2:0] m);
      return (m == MODE_NORMAL) || (m == MODE_SILENT);
   endfunction

   // Unknown codes count as low power, the safe reading
   function automatic logic is_low_power(input logic [2:0] m);
      return !is_on_mode(m);
   endfunction

endpackage

// ### src/cbb_silence_timer.sv
// Bus-silence timer: counts idle cycles, restarts on activity
`timescale 1ns/1ps
`default_nettype none
module cbb_silence_timer
   import cbb_pkg::*;
#(
   parameter int unsigned SILENCE_CYC = cbb_pkg::SILENCE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bus monitor
   input wire logic bus_active,
   output logic expired
);

   localparam int CW = $clog2(SILENCE_CYC + 1);
   localparam logic [CW-1:0] LIMIT = CW'(SILENCE_CYC);

   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
      end else if (bus_active) begin
         cnt_q <= '0;
      end else if (cnt_q != LIMIT) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign expired = (cnt_q == LIMIT);

   chk_silence_restart: assert property (
      @(posedge clk) disable iff (!reset_n)
      bus_active |=> !expired)
      else $error("silence timer not restarted by activity");

endmodule // cbb_silence_timer
`default_nettype wire

// ### src/cbb_wake_detect.sv
// Remote wake pattern detector: dominant, recessive, dominant
`timescale 1ns/1ps
`default_nettype none
module cbb_wake_detect
   import cbb_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control and bus
   input wire logic enable,
   input wire logic bus_dom,
   // Result
   output logic wake_hit
);

   localparam int FW = $clog2(WAKE_FILTER_CYC + 1);
   localparam logic [FW-1:0] FLIM = FW'(WAKE_FILTER_CYC);

   typedef enum logic [1:0] {
      WK_IDLE = 2'b00,
      WK_WAIT_REC = 2'b01,
      WK_WAIT_DOM = 2'b10
   } cbb_wk_t;

   cbb_wk_t wk_q;
   logic lvl_q;
   logic [FW-1:0] run_q;
   logic filt_dom;
   logic filt_rec;

   // Run length of the current bus level, saturating at the filter
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lvl_q <= 1'b0;
         run_q <= '0;
      end else if (bus_dom != lvl_q) begin
         lvl_q <= bus_dom;
         run_q <= '0;
      end else if (run_q != FLIM) begin
         run_q <= run_q + 1'b1;
      end
   end

   assign filt_dom = lvl_q && (run_q == FLIM);
   assign filt_rec = !lvl_q && (run_q == FLIM);

   // Short glitches between phases never rewind the pattern
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wk_q <= WK_IDLE;
      end else if (!enable) begin
         wk_q <= WK_IDLE;
      end else begin
         unique case (wk_q)
            WK_IDLE: if (filt_dom) wk_q <= WK_WAIT_REC;
            WK_WAIT_REC: if (filt_rec) wk_q <= WK_WAIT_DOM;
            WK_WAIT_DOM: if (filt_dom) wk_q <= WK_IDLE;
            default: wk_q <= WK_IDLE;
         endcase
      end
   end

   assign wake_hit = enable && (wk_q == WK_WAIT_DOM) && filt_dom;

   chk_wake_order: assert property (
      @(posedge clk) disable iff (!reset_n)
      wake_hit |-> lvl_q && $past(lvl_q) && $past(wk_q) == WK_WAIT_DOM
      ##1 wk_q == WK_IDLE)
      else $error("wake flagged out of pattern order");

endmodule // cbb_wake_detect
`default_nettype wire

// ### src/cbb_bias_ctrl.sv
// CAN bus-bias state control, driver gating and receive output
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cbb_bias_ctrl
   import cbb_pkg::*;
#(
   parameter int unsigned SILENCE_CYC = cbb_pkg::SILENCE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Supply monitors
   input wire logic batt_uv_fall,
   input wire logic batt_uv_rise,
   input wire logic xcvr_supply_uv_fall,
   input wire logic xcvr_supply_uv_rise,
   input wire logic io_supply_uv_fall,
   input wire logic io_supply_uv_rise,
   // Protocol controller side
   input wire logic tx_data,
   output logic rx_data,
   // Bus side
   input wire logic bus_dom_in,
   output logic canh_out,
   output logic canh_oe,
   output logic canl_out,
   output logic canl_oe,
   // Bias status
   output logic [1:0] bias_state,
   output logic bias_gnd,
   output logic bias_mid,
   output logic bias_half,
   output logic bus_float
);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ----------
   // Declarations
   // ----------
   cbb_bias_t state_q;
   cbb_bias_t state_d;
   logic [2:0] mode_q;
   logic [2:0] prev_mode_q;
   logic tx_block_q;
   logic wake_pend_q;
   logic drv_dom_q;
   logic rx_data_q;
   logic [31:0] rdata_q;
   logic sup_ok;
   logic sup_uv;
   logic low_pwr;
   logic active_rx;
   logic bus_dom_rx;
   logic silence_exp;
   logic wake_hit;
   logic wake_en;
   logic leave_stby;

   assign low_pwr = is_low_power(mode_q);
   assign sup_uv = xcvr_supply_uv_fall || io_supply_uv_fall;
   assign sup_ok = xcvr_supply_uv_rise && io_supply_uv_rise && !sup_uv;

   // ----------
   // Register port
   // ----------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= CTRL_MODE_RESET;
      end else if (reg_wr && reg_addr == ADDR_CTRL) begin
         mode_q <= reg_wdata[CTRL_MODE_LSB +: 3];
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= 32'h0000_0000;
         if (reg_rd && reg_addr == ADDR_CTRL) begin
            rdata_q[CTRL_MODE_LSB +: 3] <= mode_q;
         end else if (reg_rd && reg_addr == ADDR_STATUS) begin
            rdata_q[STAT_BIAS_LSB +: 2] <= state_q;
            rdata_q[STAT_WAKE_BIT] <= wake_pend_q;
            rdata_q[STAT_BLOCK_BIT] <= tx_block_q;
            rdata_q[STAT_SILENT_BIT] <= silence_exp;
            rdata_q[STAT_DRIVE_BIT] <= drv_dom_q;
         end
      end
   end

   assign reg_rdata = rdata_q;

   // ----------
   // Bus monitor
   // ----------
   // Own drive is folded in so that wired dominant wins over recessive
   assign bus_dom_rx = bus_dom_in || drv_dom_q;

   cbb_silence_timer #(
      .SILENCE_CYC(SILENCE_CYC)
   ) u_silence (
      .clk(clk),
      .reset_n(reset_n),
      .bus_active(bus_dom_rx),
      .expired(silence_exp)
   );

   assign wake_en = low_pwr && (state_q != BIAS_OFF);

   cbb_wake_detect u_wake (
      .clk(clk),
      .reset_n(reset_n),
      .enable(wake_en),
      .bus_dom(bus_dom_rx),
      .wake_hit(wake_hit)
   );

   // ----------
   // Bias state machine
   // ----------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         BIAS_OFF: begin
            if (batt_uv_rise) state_d = BIAS_AUTO_INACT;
         end
         BIAS_AUTO_INACT: begin
            if (is_normal(mode_q) && sup_ok) begin
               state_d = BIAS_ACTIVE;
            end else if (is_on_mode(mode_q) && sup_uv) begin
               state_d = BIAS_AUTO_ACT;
            end else if (wake_hit) begin
               state_d = BIAS_AUTO_ACT;
            end
         end
         BIAS_AUTO_ACT: begin
            if (is_normal(mode_q) && sup_ok) begin
               state_d = BIAS_ACTIVE;
            end else if (low_pwr && silence_exp) begin
               state_d = BIAS_AUTO_INACT;
            end
         end
         BIAS_ACTIVE: begin
            if (sup_uv) begin
               state_d = BIAS_AUTO_ACT;
            end else if (low_pwr) begin
               state_d = silence_exp ? BIAS_AUTO_INACT
                                     : BIAS_AUTO_ACT;
            end
         end
      endcase
      if (batt_uv_fall) state_d = BIAS_OFF;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= BIAS_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   assign bias_state = state_q;
   assign bus_float = (state_q == BIAS_OFF);
   assign bias_gnd = (state_q == BIAS_AUTO_INACT);
   assign bias_mid = (state_q == BIAS_AUTO_ACT);
   assign bias_half = (state_q == BIAS_ACTIVE);

   // ----------
   // Stuck-low transmit guard
   // ----------
   assign leave_stby = (prev_mode_q == MODE_STANDBY)
                       && (mode_q != MODE_STANDBY);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_mode_q <= CTRL_MODE_RESET;
      end else begin
         prev_mode_q <= mode_q;
      end
   end

   // Released only once the input has been seen high again
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_block_q <= 1'b0;
      end else if (leave_stby && !tx_data) begin
         tx_block_q <= 1'b1;
      end else if (tx_data) begin
         tx_block_q <= 1'b0;
      end
   end

   // ----------
   // Driver
   // ----------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         drv_dom_q <= 1'b0;
      end else begin
         // Battery loss cuts the driver in the same edge as the state
         drv_dom_q <= (state_q == BIAS_ACTIVE) && is_normal(mode_q)
                      && !batt_uv_fall
                      && !tx_block_q && !tx_data;
      end
   end

   assign canh_out = 1'b1;
   assign canl_out = 1'b0;
   assign canh_oe = drv_dom_q;
   assign canl_oe = drv_dom_q;

   // ----------
   // Receiver and wake flag
   // ----------
   assign active_rx = (state_q == BIAS_ACTIVE) && is_on_mode(mode_q);

   // A wake in the clearing cycle is kept; set wins over clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_pend_q <= 1'b0;
      end else if (wake_hit) begin
         wake_pend_q <= 1'b1;
      end else if (is_normal(mode_q)) begin
         wake_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_data_q <= 1'b1;
      end else if (active_rx) begin
         rx_data_q <= !bus_dom_rx;
      end else begin
         rx_data_q <= !wake_pend_q;
      end
   end

   assign rx_data = rx_data_q;

   // ----------
   // Checks
   // ----------
   sequence s_enter_active;
      state_q != BIAS_ACTIVE ##1 state_q == BIAS_ACTIVE;
   endsequence

   sequence s_leave_stby_low;
      leave_stby && !tx_data;
   endsequence

   sequence s_lp_hold;
      low_pwr && state_q != BIAS_OFF && !batt_uv_fall;
   endsequence

   chk_off_on_batt: assert property (
      batt_uv_fall |=> state_q == BIAS_OFF && bus_float && !canh_oe)
      else $error("battery undervoltage did not float the bus");

   chk_off_exit: assert property (
      state_q == BIAS_OFF && batt_uv_rise && !batt_uv_fall
      |=> state_q == BIAS_AUTO_INACT && bias_gnd)
      else $error("off state not left on battery recovery");

   chk_lp_autonomous: assert property (
      s_lp_hold |=> state_q != BIAS_ACTIVE)
      else $error("active bias held in a low-power mode");

   chk_wake_to_mid: assert property (
      state_q == BIAS_AUTO_INACT && wake_hit && low_pwr
      && !batt_uv_fall |=> bias_mid)
      else $error("remote wake did not raise mid-level bias");

   chk_silence_drop: assert property (
      state_q == BIAS_AUTO_ACT && low_pwr && silence_exp
      && !batt_uv_fall |=> state_q == BIAS_AUTO_INACT)
      else $error("silence expiry did not drop autonomous bias");

   chk_lp_choice: assert property (
      state_q == BIAS_ACTIVE && low_pwr && !sup_uv && !batt_uv_fall
      |=> state_q == ($past(silence_exp) ? BIAS_AUTO_INACT
                                         : BIAS_AUTO_ACT))
      else $error("wrong autonomous state after leaving active");

   chk_uv_leaves: assert property (
      state_q == BIAS_ACTIVE && sup_uv && !batt_uv_fall
      |=> state_q == BIAS_AUTO_ACT)
      else $error("supply undervoltage kept active bias");

   chk_uv_lift: assert property (
      state_q == BIAS_AUTO_INACT && is_on_mode(mode_q) && sup_uv
      && !batt_uv_fall |=> state_q == BIAS_AUTO_ACT)
      else $error("on request under undervoltage not lifted");

   chk_active_gate: assert property (
      s_enter_active |-> $past(is_normal(mode_q)) && $past(sup_ok))
      else $error("active entered without normal mode and good supply");

   chk_stuck_block: assert property (
      s_leave_stby_low |=> tx_block_q ##1 !canh_oe)
      else $error("stuck-low transmit input not blocked");

   chk_dom_drive: assert property (
      state_q == BIAS_ACTIVE && is_normal(mode_q) && !tx_block_q
      && !tx_data && !batt_uv_fall |=> canh_oe && canl_oe)
      else $error("low transmit input not driven dominant");

   chk_rx_dom: assert property (
      active_rx && bus_dom_rx |=> !rx_data)
      else $error("dominant bus not shown low on receive");

   chk_tx_high: assert property (
      tx_data |=> !canh_oe && !canl_oe)
      else $error("bus driven while transmit input high");

   chk_quiet_modes: assert property (
      !is_normal(mode_q) |=> !canh_oe && !canl_oe)
      else $error("driver on outside normal mode");

   chk_rx_standby: assert property (
      !active_rx && !wake_pend_q |=> rx_data)
      else $error("receive output low with no wake pending");

endmodule // cbb_bias_ctrl
`default_nettype wire

// ### test/cbb_ctrl_model.sv
// Protocol controller model driving the transmit pin
`timescale 1ns/1ps
`default_nettype none
module cbb_ctrl_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bench control
   input wire logic dom_req,
   input wire logic slow,
   // Transceiver pin
   output logic tx_data
);
   logic req_q;

   // ----------
   // Transmit drive
   // ----------
   // Slow mode answers a cycle later, as a busy controller would
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         req_q <= 1'b0;
         tx_data <= 1'b1;
      end else begin
         req_q <= dom_req;
         tx_data <= !(slow ? req_q : dom_req);
      end
   end
endmodule // cbb_ctrl_model
`default_nettype wire

// ### test/can_bus_bias_state_control_tb.sv
// Self-checking testbench for the CAN bus-bias controller
`timescale 1ns/1ps
`default_nettype none
module can_bus_bias_state_control_tb
   import cbb_pkg::*;
   ;
   localparam int unsigned SIL = 50;
   logic clk, reset_n, reg_wr, reg_rd, rd_pend;
   logic [3:0] reg_addr, a;
   logic [31:0] reg_wdata, reg_rdata;
   logic [31:0] exp_q[$];
   logic batt_uv_fall, batt_uv_rise, xcvr_supply_uv_fall;
   logic xcvr_supply_uv_rise, io_supply_uv_fall, io_supply_uv_rise;
   logic tx_data, rx_data, bus_dom_in, canh_oe, canl_oe;
   logic canh_out, canl_out;
   logic bias_gnd, bias_mid, bias_half, bus_float, dom_req, slow;
   logic [1:0] bias_state;
   int error_cnt, cmp_count, seed, n;
   int unsigned ph[5] = '{15, 3, 3, 15, 15};

   cbb_bias_ctrl #(.SILENCE_CYC(SIL)) u_cbb_bias_ctrl (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .batt_uv_fall(batt_uv_fall),
      .batt_uv_rise(batt_uv_rise),
      .xcvr_supply_uv_fall(xcvr_supply_uv_fall),
      .xcvr_supply_uv_rise(xcvr_supply_uv_rise),
      .io_supply_uv_fall(io_supply_uv_fall),
      .io_supply_uv_rise(io_supply_uv_rise), .tx_data(tx_data),
      .rx_data(rx_data), .bus_dom_in(bus_dom_in), .canh_out(canh_out),
      .canh_oe(canh_oe), .canl_out(canl_out), .canl_oe(canl_oe),
      .bias_state(bias_state), .bias_gnd(bias_gnd), .bias_mid(bias_mid),
      .bias_half(bias_half), .bus_float(bus_float));

   cbb_ctrl_model u_cbb_ctrl_model (
      .clk(clk), .reset_n(reset_n), .dom_req(dom_req), .slow(slow),
      .tx_data(tx_data));

   // ----------
   // Compare and bus tasks
   // ----------
   task automatic chk(input logic [7:0] got, input logic [7:0] e);
      cmp_count++;
      if (got !== e) begin
         error_cnt++;
         $display("unexpected at %0t: pin got %h want %h", $time, got, e);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] e);
      cmp_count++;
      if (got !== e) begin
         error_cnt++;
         $display("unexpected at %0t: read %h want %h", $time, got, e);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic rd(input logic [3:0] ad, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Settle, check the state decodes, then read STATUS
   task automatic st(input logic [5:0] e);
      cyc(2);
      @(negedge clk);
      chk({2'h0, bias_state, bus_float, bias_half, bias_mid, bias_gnd},
          {2'h0, e[1:0], e[1:0] == 2'b00, e[1:0] == 2'b11,
           e[1:0] == 2'b10, e[1:0] == 2'b01});
      rd(ADDR_STATUS, {26'h0, e});
   endtask

   // Returns on a rising edge so that the next drive lands there
   task automatic pins(input logic oe, input logic rx);
      @(negedge clk);
      chk({3'h0, canh_out, canl_out, canh_oe, canl_oe, rx_data},
          {3'h0, 2'b10, oe, oe, rx});
      @(posedge clk);
   endtask

   task automatic uv(input int i, input logic b);
      @(posedge clk);
      if (i == 0) begin
         xcvr_supply_uv_fall <= b;
         xcvr_supply_uv_rise <= !b;
      end else begin
         io_supply_uv_fall <= b;
         io_supply_uv_rise <= !b;
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------
   // Read monitor: pops the oldest note when read data stand
   // ----------
   always @(posedge clk) rd_pend <= reg_rd;

   // Sampled mid-cycle, where the registered read data have settled
   always @(negedge clk) begin
      if (rd_pend) begin
         if (exp_q.size() == 0)
            chk_word(reg_rdata, 32'hxxxx_xxxx);
         else
            chk_word(reg_rdata, exp_q.pop_front());
      end
   end

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      repeat (4000) @(posedge clk);
      error_cnt++;
      final_report();
   end

   // ----------
   // Main sequence
   // ----------
   initial begin
      seed = 29535;
      {reset_n, reg_wr, reg_rd, bus_dom_in, dom_req} = '0;
      {reg_addr, reg_wdata, error_cnt, cmp_count} = '0;
      {slow, batt_uv_fall, xcvr_supply_uv_fall, io_supply_uv_fall} = '0;
      {batt_uv_rise, xcvr_supply_uv_rise, io_supply_uv_rise} = 3'h7;
      cyc(10);
      reset_n <= 1'b1;
      st(6'h01);
      rd(ADDR_CTRL, 32'h0000_0002);
      n = $random(seed);
      a = {1'b1, n[2:0]};
      rd(a, 32'h0000_0000);
      wr(a, 32'h0000_0000);
      rd(ADDR_CTRL, 32'h0000_0002);
      // Wake pattern with a short glitch inside the recessive phase
      for (int k = 0; k < 5; k++) begin
         bus_dom_in <= !k[0];
         cyc(ph[k]);
      end
      bus_dom_in <= 1'b0;
      st(6'h06);
      pins(1'b0, 1'b0);
      cyc(SIL + 10);
      st(6'h15);
      dom_req <= 1'b1;
      cyc(3);
      wr(ADDR_CTRL, 32'h0000_0000);
      st(6'h1b);
      pins(1'b0, 1'b1);
      dom_req <= 1'b0;
      cyc(4);
      for (int s = 0; s < 2; s++) begin
         slow <= s[0];
         n = 5 + ($unsigned($random(seed)) % 4);
         dom_req <= 1'b1;
         cyc(n);
         pins(1'b1, 1'b0);
         st(6'h23);
         dom_req <= 1'b0;
         cyc(5);
         pins(1'b0, 1'b1);
      end
      bus_dom_in <= 1'b1;
      cyc(3);
      pins(1'b0, 1'b0);
      bus_dom_in <= 1'b0;
      wr(ADDR_CTRL, 32'h0000_0001);
      dom_req <= 1'b1;
      cyc(4);
      pins(1'b0, 1'b1);
      st(6'h03);
      bus_dom_in <= 1'b1;
      cyc(3);
      pins(1'b0, 1'b0);
      bus_dom_in <= 1'b0;
      dom_req <= 1'b0;
      wr(ADDR_CTRL, 32'h0000_0002);
      st(6'h02);
      pins(1'b0, 1'b1);
      cyc(SIL + 10);
      st(6'h11);
      wr(ADDR_CTRL, 32'h0000_0000);
      st(6'h13);
      wr(ADDR_CTRL, 32'h0000_0004);
      st(6'h11);
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_CTRL, 32'h0000_0000);
         st(6'h13);
         uv(i, 1'b1);
         st(6'h12);
         wr(ADDR_CTRL, 32'h0000_0002);
         st(6'h11);
         wr(ADDR_CTRL, 32'h0000_0000);
         st(6'h12);
         uv(i, 1'b0);
         st(6'h13);
         wr(ADDR_CTRL, 32'h0000_0002);
         st(6'h11);
      end
      batt_uv_fall <= 1'b1;
      batt_uv_rise <= 1'b0;
      st(6'h10);
      pins(1'b0, 1'b1);
      batt_uv_fall <= 1'b0;
      batt_uv_rise <= 1'b1;
      st(6'h11);
      cyc(3);
      final_report();
   end
endmodule // can_bus_bias_state_control_tb
`default_nettype wire
